/* File: verilog/wei_routing.sv */
// wake-up event routing to the interrupt channel and detector gating
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "wei_routing_regs.svh"
module wei_routing
  import wei_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic [1:0] config_bank,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic main_power_present,
  input wire logic software_event,
  input wire logic ring_indicator_one,
  input wire logic ring_indicator_two,
  input wire logic keyboard_event,
  input wire logic mouse_event,
  input wire logic consumer_infrared_event,
  input wire logic [7:0] general_input_event,
  output logic [7:0] detected_low,
  output logic [7:0] detected_gpin,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // register select

  function automatic wei_sel_t wei_decode(input logic [1:0] bank, input logic [7:0] addr);
    wei_sel_t sel;
    sel = WEI_SEL_NONE;
    if (bank == `WEI_BANK_ROUTING) begin
      case (addr)
        `WEI_OFF_ROUTE_LOW: sel = WEI_SEL_ROUTE_LOW;
        `WEI_OFF_ROUTE_GPIN: sel = WEI_SEL_ROUTE_GPIN;
        `WEI_OFF_GATE_LOW: sel = WEI_SEL_GATE_LOW;
        `WEI_OFF_GATE_GPIN: sel = WEI_SEL_GATE_GPIN;
        `WEI_OFF_STAT_LOW: sel = WEI_SEL_STAT_LOW;
        `WEI_OFF_STAT_GPIN: sel = WEI_SEL_STAT_GPIN;
        default: sel = WEI_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  wei_sel_t wr_sel;
  wei_sel_t rd_sel;

  always_comb begin
    wr_sel = reg_wr ? wei_decode(config_bank, reg_addr) : WEI_SEL_NONE;
    rd_sel = reg_rd ? wei_decode(config_bank, reg_addr) : WEI_SEL_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int NUM_PINS = `WEI_NUM_LOW_PINS + `WEI_NUM_GPIN + 1;

  logic [NUM_PINS-1:0] pins_sync;
  logic [4:0] raw_low_sync;
  logic [7:0] raw_gpin_sync;
  logic power_sync;

  wei_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({main_power_present, general_input_event, consumer_infrared_event,
               mouse_event, keyboard_event, ring_indicator_two, ring_indicator_one}),
    .sync_out(pins_sync)
  );

  always_comb begin
    raw_low_sync = pins_sync[4:0];
    raw_gpin_sync = pins_sync[12:5];
    power_sync = pins_sync[13];
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  wei_byte_t route_low;
  wei_byte_t route_gpin;
  wei_byte_t gate_low;
  wei_byte_t gate_gpin;
  wei_byte_t next_route_low;
  wei_byte_t next_route_gpin;
  wei_byte_t next_gate_low;
  wei_byte_t next_gate_gpin;

  always_comb begin
    next_route_low = route_low;
    next_route_gpin = route_gpin;
    next_gate_low = gate_low;
    next_gate_gpin = gate_gpin;
    if (soft_reset) begin
      next_route_low = `WEI_RST_ROUTE_LOW;
      next_route_gpin = `WEI_RST_ROUTE_GPIN;
      next_gate_low = `WEI_RST_GATE_LOW;
      next_gate_gpin = `WEI_RST_GATE_GPIN;
    end else begin
      unique case (wr_sel)
        WEI_SEL_ROUTE_LOW: next_route_low = reg_wdata & `WEI_MASK_ROUTE_LOW;
        WEI_SEL_ROUTE_GPIN: next_route_gpin = reg_wdata & `WEI_MASK_GPIN;
        WEI_SEL_GATE_LOW: next_gate_low = reg_wdata & `WEI_MASK_GATE_LOW;
        WEI_SEL_GATE_GPIN: next_gate_gpin = reg_wdata & `WEI_MASK_GPIN;
        default: next_route_low = route_low;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      route_low <= `WEI_RST_ROUTE_LOW;
      route_gpin <= `WEI_RST_ROUTE_GPIN;
      gate_low <= `WEI_RST_GATE_LOW;
      gate_gpin <= `WEI_RST_GATE_GPIN;
    end else begin
      route_low <= next_route_low;
      route_gpin <= next_route_gpin;
      gate_low <= next_gate_low;
      gate_gpin <= next_gate_gpin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detectors

  wei_byte_t event_low;
  wei_byte_t pass_low;
  wei_byte_t pass_gpin;
  wei_byte_t clear_low;
  wei_byte_t clear_gpin;

  always_comb begin
    event_low = '0;
    event_low[4:0] = raw_low_sync;
    event_low[`WEI_BIT_SOFTWARE] = software_event;
    // pin events pass only with main supply and gating bit
    pass_low = '0;
    pass_low[4:0] = gate_low[4:0] & {5{power_sync}};
    pass_low[`WEI_BIT_SOFTWARE] = 1'b1;
    pass_gpin = gate_gpin & {8{power_sync}};
    clear_low = (wr_sel == WEI_SEL_STAT_LOW) ? reg_wdata : '0;
    clear_gpin = (wr_sel == WEI_SEL_STAT_GPIN) ? reg_wdata : '0;
  end

  wei_detect #(
    .WIDTH(8)
  ) u_detect_low (
    .mclk(mclk),
    .reset_n(reset_n),
    .soft_reset(soft_reset),
    .event_in(event_low),
    .gate(pass_low),
    .clear(clear_low),
    .detected(detected_low)
  );

  wei_detect #(
    .WIDTH(8)
  ) u_detect_gpin (
    .mclk(mclk),
    .reset_n(reset_n),
    .soft_reset(soft_reset),
    .event_in(raw_gpin_sync),
    .gate(pass_gpin),
    .clear(clear_gpin),
    .detected(detected_gpin)
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt and read data

  logic next_irq;
  wei_byte_t next_rdata;

  always_comb begin
    next_irq = (|(detected_low & route_low)) | (|(detected_gpin & route_gpin));
    next_rdata = `WEI_RDATA_IDLE;
    unique case (rd_sel)
      WEI_SEL_ROUTE_LOW: next_rdata = route_low;
      WEI_SEL_ROUTE_GPIN: next_rdata = route_gpin;
      WEI_SEL_GATE_LOW: next_rdata = gate_low;
      WEI_SEL_GATE_GPIN: next_rdata = gate_gpin;
      WEI_SEL_STAT_LOW: next_rdata = detected_low;
      WEI_SEL_STAT_GPIN: next_rdata = detected_gpin;
      default: next_rdata = `WEI_RDATA_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      reg_rdata <= `WEI_RDATA_IDLE;
    end else begin
      irq <= next_irq;
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_route_reset;
    soft_reset |=> (route_low == `WEI_RST_ROUTE_LOW) && (route_gpin == `WEI_RST_ROUTE_GPIN);
  endproperty
  a_route_reset: assert property (p_route_reset) else $error("routing enables not cleared");

  property p_irq_low;
    (|(detected_low & route_low)) |=> irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("routed low event without interrupt");

  property p_route_low_layout;
    (wr_sel == WEI_SEL_ROUTE_LOW) && !soft_reset |=> route_low == ($past(reg_wdata) & `WEI_MASK_ROUTE_LOW);
  endproperty
  a_route_low_layout: assert property (p_route_low_layout) else $error("low routing layout wrong");

  property p_irq_gpin;
    (|(detected_gpin & route_gpin)) |=> irq;
  endproperty
  a_irq_gpin: assert property (p_irq_gpin) else $error("routed input event without interrupt");

  property p_irq_quiet;
    !(|(detected_low & route_low)) && !(|(detected_gpin & route_gpin)) |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without routed event");

  property p_route_gpin_write;
    (wr_sel == WEI_SEL_ROUTE_GPIN) && !soft_reset |=> route_gpin == $past(reg_wdata);
  endproperty
  a_route_gpin_write: assert property (p_route_gpin_write) else $error("input routing not written");

  property p_gate_reset;
    soft_reset |=> (gate_low == `WEI_RST_GATE_LOW) ##0 (gate_gpin == `WEI_RST_GATE_GPIN);
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gating reset values wrong");

  property p_gate_gpin_reset;
    soft_reset |=> gate_gpin == `WEI_RST_GATE_GPIN;
  endproperty
  a_gate_gpin_reset: assert property (p_gate_gpin_reset) else $error("input gating reset value wrong");

  property p_no_power_no_detect;
    !power_sync && !soft_reset |=> (detected_gpin & ~$past(detected_gpin)) == 8'h00;
  endproperty
  a_no_power_no_detect: assert property (p_no_power_no_detect) else $error("event without supply");

  // software event is not supply gated, so only the five pin bits are watched
  property p_low_no_power;
    !power_sync && !soft_reset |=> (detected_low[4:0] & ~$past(detected_low[4:0])) == 5'h00;
  endproperty
  a_low_no_power: assert property (p_low_no_power) else $error("pin event without supply");

  property p_gate_low_layout;
    (wr_sel == WEI_SEL_GATE_LOW) && !soft_reset |=> gate_low[7:5] == 3'h0;
  endproperty
  a_gate_low_layout: assert property (p_gate_low_layout) else $error("low gating reserved bits set");

  property p_gpin_blocked;
    1'b1 |=> (detected_gpin & ~$past(detected_gpin) & ~$past(gate_gpin)) == 8'h00;
  endproperty
  a_gpin_blocked: assert property (p_gpin_blocked) else $error("blocked input event latched");

  property p_low_blocked;
    1'b1 |=> (detected_low[4:0] & ~$past(detected_low[4:0]) & ~$past(gate_low[4:0])) == 5'h00;
  endproperty
  a_low_blocked: assert property (p_low_blocked) else $error("blocked low event latched");

  property p_pin_to_irq;
    power_sync && gate_gpin[0] && route_gpin[0] && $rose(raw_gpin_sync[0]) && !soft_reset
      ##1 !soft_reset && route_gpin[0] |=> irq;
  endproperty
  a_pin_to_irq: assert property (p_pin_to_irq) else $error("input edge did not interrupt");

  property p_read_only_once;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_read_only_once: assert property (p_read_only_once) else $error("read data outside read");

  c_irq_rise: cover property ($rose(irq));
  c_software_event: cover property ($rose(detected_low[`WEI_BIT_SOFTWARE]));
  c_gate_cleared: cover property ((wr_sel == WEI_SEL_GATE_GPIN) && (reg_wdata == 8'h00));
  c_status_clear: cover property ((wr_sel == WEI_SEL_STAT_LOW) ##1 !irq);

endmodule

/* File: verilog/wei_routing_regs.svh */
// register offsets, reset values and field positions of the wake-up event routing block
`ifndef WEI_ROUTING_REGS_SVH
`define WEI_ROUTING_REGS_SVH

`define WEI_BANK_ROUTING 2'h2

`define WEI_OFF_ROUTE_LOW 8'h15
`define WEI_OFF_ROUTE_GPIN 8'h16
`define WEI_OFF_GATE_LOW 8'h17
`define WEI_OFF_GATE_GPIN 8'h18
`define WEI_OFF_STAT_LOW 8'h1d
`define WEI_OFF_STAT_GPIN 8'h1e

`define WEI_RST_ROUTE_LOW 8'h00
`define WEI_RST_ROUTE_GPIN 8'h00
`define WEI_RST_GATE_LOW 8'h1f
`define WEI_RST_GATE_GPIN 8'hff
`define WEI_RST_STAT 8'h00
`define WEI_RDATA_IDLE 8'h00

`define WEI_MASK_ROUTE_LOW 8'h5f
`define WEI_MASK_GATE_LOW 8'h1f
`define WEI_MASK_GPIN 8'hff

`define WEI_BIT_RING_ONE 0
`define WEI_BIT_RING_TWO 1
`define WEI_BIT_KEYBOARD 2
`define WEI_BIT_MOUSE 3
`define WEI_BIT_INFRARED 4
`define WEI_BIT_SOFTWARE 6
`define WEI_BIT_GPIN_RING 4

`define WEI_NUM_LOW_PINS 5
`define WEI_NUM_GPIN 8

`endif

/* File: verilog/wei_pkg.sv */
// types shared by the wake-up event routing block
package wei_pkg;

  typedef logic [7:0] wei_byte_t;

  // one-hot register select
  typedef enum logic [5:0] {
    WEI_SEL_NONE = 6'h00,
    WEI_SEL_ROUTE_LOW = 6'h01,
    WEI_SEL_ROUTE_GPIN = 6'h02,
    WEI_SEL_GATE_LOW = 6'h04,
    WEI_SEL_GATE_GPIN = 6'h08,
    WEI_SEL_STAT_LOW = 6'h10,
    WEI_SEL_STAT_GPIN = 6'h20
  } wei_sel_t;

endpackage

/* File: verilog/wei_sync.sv */
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module wei_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

/* File: verilog/wei_detect.sv */
// gated rising-edge event detectors with sticky status, write-one-to-clear
`timescale 1ns/1ps
module wei_detect #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] gate,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] detected
);

  logic [WIDTH-1:0] prev_event;
  logic [WIDTH-1:0] next_prev_event;
  logic [WIDTH-1:0] next_detected;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_prev_event[i] = event_in[i];
        // blocked edges never reach the latch; set beats clear
        if (soft_reset) begin
          next_detected[i] = 1'b0;
        end else begin
          next_detected[i] = (detected[i] & ~clear[i]) |
                             (event_in[i] & ~prev_event[i] & gate[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_event <= '0;
      detected <= '0;
    end else begin
      prev_event <= next_prev_event;
      detected <= next_detected;
    end
  end

endmodule

/* File: tb/wei_irq_host.sv */
// host interrupt controller model: counts requests raised on the level interrupt line
`timescale 1ns/1ps
module wei_irq_host (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic irq,
  output logic [7:0] irq_count
);
  logic irq_d;

  // a level request is taken once per rise; the line must drop before the next one counts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_d <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      irq_d <= irq;
      if (irq && !irq_d) begin
        irq_count <= irq_count + 8'h01;
      end
    end
  end
endmodule

/* File: tb/wei_routing_tb.sv */
// self-checking bench of the wake-up event routing block
`timescale 1ns/1ps
module wei_routing_tb;
  logic mclk, reset_n, soft_reset, reg_wr, reg_rd, main_power_present, software_event, irq;
  logic [1:0] config_bank;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, detected_low, detected_gpin, irq_count, m;
  logic [12:0] pins;
  logic [7:0] offs[4] = '{8'h15, 8'h16, 8'h17, 8'h18};
  logic [7:0] rstv[4] = '{8'h00, 8'h00, 8'h1f, 8'hff};
  logic [7:0] full[4] = '{8'h5f, 8'hff, 8'h1f, 8'hff};
  int err_count = 0;
  int total_checks = 0;

  wei_routing u_wei_routing (.mclk(mclk), .reset_n(reset_n), .soft_reset(soft_reset),
    .config_bank(config_bank), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_power_present(main_power_present),
    .software_event(software_event), .ring_indicator_one(pins[0]), .ring_indicator_two(pins[1]),
    .keyboard_event(pins[2]), .mouse_event(pins[3]), .consumer_infrared_event(pins[4]),
    .general_input_event(pins[12:5]), .detected_low(detected_low), .detected_gpin(detected_gpin),
    .irq(irq));

  wei_irq_host u_wei_irq_host (.mclk(mclk), .reset_n(reset_n), .irq(irq), .irq_count(irq_count));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // rise held 4 cycles, then low 4 cycles so the next rise is a fresh edge
  task automatic pulse(input int i);
    @(posedge mclk);
    pins[i] <= 1'b1;
    repeat (4) @(posedge mclk);
    pins[i] <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic clear_status();
    wr(8'h1d, 8'hff);
    wr(8'h1e, 8'hff);
    repeat (2) @(posedge mclk);
    #1;
    chk(detected_low | detected_gpin, 8'h00);
    chk({7'h0, irq}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    soft_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    config_bank = 2'h2;
    main_power_present = 1'b1;
    software_event = 1'b0;
    pins = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(offs[i], rstv[i]);
    for (int i = 0; i < 4; i++) wr(offs[i], 8'hff);
    for (int i = 0; i < 4; i++) rd(offs[i], full[i]);
    for (int i = 0; i < 4; i++) wr(offs[i], rstv[i]);
    rd(8'h30, 8'h00);
    // other bank refuses the write
    @(posedge mclk) config_bank <= 2'h1;
    wr(8'h17, 8'h00);
    @(posedge mclk) config_bank <= 2'h2;
    rd(8'h17, 8'h1f);
    for (int i = 0; i < 13; i++) begin
      m = 8'h01 << (i < 5 ? i : i - 5);
      wr(i < 5 ? 8'h15 : 8'h16, m);
      pulse(i);
      chk(i < 5 ? detected_low : detected_gpin, m);
      chk({7'h0, irq}, 8'h01);
      rd(i < 5 ? 8'h1d : 8'h1e, m);
      clear_status();
    end
    wr(8'h15, 8'h40);
    @(posedge mclk) software_event <= 1'b1;
    @(posedge mclk) software_event <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(detected_low, 8'h40);
    chk({7'h0, irq}, 8'h01);
    clear_status();
    // supply absent blocks the pin event
    wr(8'h15, 8'h01);
    @(posedge mclk) main_power_present <= 1'b0;
    repeat (4) @(posedge mclk);
    pulse(0);
    chk(detected_low, 8'h00);
    chk({7'h0, irq}, 8'h00);
    @(posedge mclk) main_power_present <= 1'b1;
    repeat (4) @(posedge mclk);
    // gate bit cleared blocks the input event
    wr(8'h18, 8'hfe);
    wr(8'h16, 8'h01);
    pulse(5);
    chk(detected_gpin, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(8'h17, 8'h00);
    @(posedge mclk) soft_reset <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd(offs[i], rstv[i]);
    chk(irq_count, 8'h0e);
    close_out();
  end
endmodule
